// File: exc_defines.vh
// Constants for the exception cause and reset unit.
// Included by every design file of the unit; definitions only.
`ifndef EXC_DEFINES_VH
`define EXC_DEFINES_VH
// Register addresses in the control address area (28-bit address)
`define ADDR_W          28
`define ADDR_SCI        28'hfffffd0
`define ADDR_ECR        28'hfffffd4
`define ADDR_ICR        28'hfffffd8
// Cause codes
`define C_POR           12'h000
`define C_MRST          12'h020
`define C_TLB_LD        12'h040
`define C_TLB_ST        12'h060
`define C_IPW           12'h080
`define C_PROT_LD       12'h0a0
`define C_PROT_ST       12'h0c0
`define C_ADR_LD        12'h0e0
`define C_ADR_ST        12'h100
`define C_SWCALL        12'h160
`define C_UNDEF         12'h180
`define C_SLOT          12'h1a0
`define C_NMI           12'h1c0
`define C_UBRK          12'h1e0
`define C_EXT_BASE      12'h200
`define C_PER_BASE      12'h400
`define C_STEP_SH       5
`define IRL_NONE        4'hf
`define NUM_PER         14
// Reset vector and status word layout
`define RST_VEC         32'ha0000000
`define SW_W            32
`define SW_PRIV         30
`define SW_BANK         29
`define SW_BLK          28
`define SW_IMASK_LO     4
`define SW_IMASK_HI     7
`define SW_RST          32'h700000f0
// General exception kinds (exc_kind_i)
`define K_TLB_LD        4'h0
`define K_TLB_ST        4'h1
`define K_IPW           4'h2
`define K_PROT_LD       4'h3
`define K_PROT_ST       4'h4
`define K_ADR_LD        4'h5
`define K_ADR_ST        4'h6
`define K_UNDEF         4'h7
`define K_SLOT          4'h8
`define K_UBRK          4'h9
`define K_SWCALL        4'ha
`endif

// File: cause_store.v
// Three cause registers with their own update and software write port.
// Assumes the main unit resolves priority; read data leave a register.
`timescale 1ns/100ps
`include "exc_defines.vh"
module cause_store
(
	// Clock and reset
	input  wire        mclk_i,
	input  wire        rst_i,
	// Hardware loads
	input  wire        ecr_ld_i,
	input  wire [11:0] ecr_val_i,
	input  wire        icr_ld_i,
	input  wire [11:0] icr_val_i,
	input  wire        sci_ld_i,
	input  wire [7:0]  sci_val_i,
	// Software access
	input  wire [1:0]  sel_i,
	input  wire        wr_i,
	input  wire        rd_i,
	input  wire [11:0] wdata_i,
	output wire [11:0] ecr_o,
	output reg  [11:0] rdata_o
);
	reg [11:0] ecr_ff;
	reg [11:0] icr_ff;
	reg [7:0]  sci_ff;

	assign ecr_o = ecr_ff;

	// Hardware load wins over a software write in the same cycle
	always @(posedge mclk_i)
	begin
		if (ecr_ld_i)
			ecr_ff <= ecr_val_i;
		else if (wr_i && sel_i == 2'h1)
			ecr_ff <= wdata_i;
		if (icr_ld_i)
			icr_ff <= icr_val_i;
		else if (wr_i && sel_i == 2'h2)
			icr_ff <= wdata_i;
		if (sci_ld_i)
			sci_ff <= sci_val_i;
		else if (wr_i && sel_i == 2'h0)
			sci_ff <= wdata_i[7:0];
		if (rst_i)
			rdata_o <= 12'h000;
		else if (rd_i)
		begin
			case (sel_i)
				2'h0:    rdata_o <= {4'h0, sci_ff};
				2'h1:    rdata_o <= ecr_ff;
				2'h2:    rdata_o <= icr_ff;
				default: rdata_o <= 12'h000;
			endcase
		end
	end
endmodule // cause_store

// File: exception_cause_and_reset_unit.v
// Exception cause coding, block-flag policy, return restore, reset sequence.
// Assumes the pipeline gives one-cycle event strobes and interrupt requests are held until taken.
//
// Behaviour
// - Reset and exceptions load the exception cause, interrupts the interrupt cause.
// - Power-on reset writes 0x000, manual reset 0x020.
// - Miss/invalid gives 0x040 load, 0x060 store; clean page write 0x080.
// - Protection violation gives 0x0a0 load, 0x0c0 store.
// - Address error gives 0x0e0 read, 0x100 write.
// - Software call records 0x160.
// - Undefined opcode 0x180, illegal delay slot instruction 0x1a0.
// - User breakpoint 0x1e0 exception; nonmaskable interrupt 0x1c0 interrupt.
// - Codes 0x120, 0x140 and 0x3e0 are never produced.
// - Block flag clear accepts exceptions and interrupts.
// - Exception with block flag set resets the CPU and jumps to reset vector.
// - Interrupts with block flag set stay pending until it clears.
// - Return loads PC and status word from their saved copies.
// - Registers reachable only in the control area and privileged mode.
// - Exception cause register loaded by hardware, writable by software.
// - Interrupt cause register loaded on acceptance, writable by software.
// - Software call loads its immediate; software may write it too.
// - Reset pin sampled every clock; power-on reset halts all at once.
// - Manual reset keeps external memory preserving work running.
// - Bus request pin high means power-on, low means manual reset.
// - Reset sets privilege, block, bank flags, writes cause, fetches vector.
`timescale 1ns/100ps
`include "exc_defines.vh"
module exception_cause_and_reset_unit
(
	// Clock and reset
	input  wire                mclk_i,
	input  wire                rst_i,
	// Reset pins, active low, asynchronous to the clock
	input  wire                reset_pin_n_i,
	input  wire                bus_request_pin_n_i,
	// General exception report from the pipeline
	input  wire                exc_req_i,
	input  wire [3:0]          exc_kind_i,
	input  wire [7:0]          swcall_imm_i,
	input  wire [31:0]         cur_pc_i,
	input  wire [31:0]         next_pc_i,
	// Interrupt requests
	input  wire                nmi_i,
	input  wire [3:0]          encoded_interrupt_level_i,
	input  wire [13:0]         periph_irq_i,
	// Return from exception and status word access
	input  wire                rte_i,
	input  wire                sw_wr_i,
	input  wire [31:0]         sw_wdata_i,
	input  wire                spc_wr_i,
	input  wire                ssr_wr_i,
	// Register access in the control area
	input  wire                reg_rd_i,
	input  wire                reg_wr_i,
	input  wire [27:0]         reg_addr_i,
	input  wire [11:0]         reg_wdata_i,
	output wire [11:0]         reg_rdata_o,
	output reg                 reg_err_o,
	// Core control
	output reg                 redirect_o,
	output reg  [31:0]         redirect_pc_o,
	output reg                 cpu_reset_o,
	output reg                 halt_all_o,
	output reg                 mem_keep_o,
	output reg                 irq_taken_o,
	output wire                irq_pending_o,
	output reg  [31:0]         status_word_o,
	output reg  [31:0]         saved_pc_o,
	output reg  [31:0]         saved_status_word_o
);
	// ****************************************************************
	// Pin synchronisers
	// ****************************************************************
	// Both pins pass the same two stages, so the reset and its kind
	// reach the sequencer in the same cycle
	reg  [1:0] rst_sync_ff;
	reg  [1:0] bus_request_pin_sync_ff;
	always @(posedge mclk_i)
	begin
		if (rst_i)
		begin
			rst_sync_ff  <= 2'h3;
			bus_request_pin_sync_ff <= 2'h3;
		end
		else
		begin
			rst_sync_ff  <= {rst_sync_ff[0], reset_pin_n_i};
			bus_request_pin_sync_ff <= {bus_request_pin_sync_ff[0], bus_request_pin_n_i};
		end
	end
	wire pin_rst    = ~rst_sync_ff[1];
	wire pin_por    = pin_rst & bus_request_pin_sync_ff[1];
	wire pin_manual = pin_rst & ~bus_request_pin_sync_ff[1];

	// ****************************************************************
	// Reset sequencer
	// ****************************************************************
	// An illegal state code falls back into the reset state
	localparam S_RUN  = 3'b001;
	localparam S_RST  = 3'b010;
	localparam S_VEC  = 3'b100;
	reg  [2:0] state_ff;
	reg  [2:0] nxt_state;
	reg        por_ff;
	always @*
	begin
		nxt_state = state_ff;
		case (state_ff)
			S_RUN:   if (pin_rst) nxt_state = S_RST;
			S_RST:   if (!pin_rst) nxt_state = S_VEC;
			S_VEC:   nxt_state = pin_rst ? S_RST : S_RUN;
			default: nxt_state = S_RST;
		endcase
	end
	always @(posedge mclk_i)
	begin
		if (rst_i)
		begin
			state_ff <= S_RST;
			por_ff   <= 1'b1;
		end
		else
		begin
			state_ff <= nxt_state;
			// Kind is only relearned while the pin is low, so a late
			// bus request change cannot relabel a finished reset
			if (pin_rst)
				por_ff <= pin_por;
		end
	end
	wire in_reset = (state_ff == S_RST);

	// ****************************************************************
	// Cause encoding
	// ****************************************************************
	reg  [11:0] exc_code;
	always @*
	begin
		case (exc_kind_i)
			`K_TLB_LD:  exc_code = `C_TLB_LD;
			`K_TLB_ST:  exc_code = `C_TLB_ST;
			`K_IPW:     exc_code = `C_IPW;
			`K_PROT_LD: exc_code = `C_PROT_LD;
			`K_PROT_ST: exc_code = `C_PROT_ST;
			`K_ADR_LD:  exc_code = `C_ADR_LD;
			`K_ADR_ST:  exc_code = `C_ADR_ST;
			`K_SWCALL:  exc_code = `C_SWCALL;
			`K_UNDEF:   exc_code = `C_UNDEF;
			`K_SLOT:    exc_code = `C_SLOT;
			`K_UBRK:    exc_code = `C_UBRK;
			// Unknown kinds are never taken (exc_kind_ok), so this default never reaches the cause
			default:    exc_code = `C_UNDEF;
		endcase
	end
	wire exc_kind_ok = (exc_kind_i <= `K_SWCALL);

	// Peripheral priority: lowest index first, fixed code per source
	wire [11:0] per_code [0:`NUM_PER];
	wire [`NUM_PER:0] per_hit;
	assign per_code[0] = 12'h000;
	assign per_hit[0]  = 1'b0;
	genvar gi;
	generate
		for (gi = 0; gi < `NUM_PER; gi = gi + 1)
		begin : g_per
			localparam integer OWN_CODE = `C_PER_BASE + (gi << `C_STEP_SH);
			wire [11:0]        own      = OWN_CODE[11:0];
			assign per_hit[gi+1]  = per_hit[gi] | periph_irq_i[gi];
			assign per_code[gi+1] = per_hit[gi] ? per_code[gi] : own;
		end
	endgenerate

	// All-ones level is the idle value, so no code is formed from it
	wire        ext_req  = (encoded_interrupt_level_i != `IRL_NONE);
	wire [11:0] ext_code = `C_EXT_BASE +
		({8'h00, encoded_interrupt_level_i} << `C_STEP_SH);
	wire        irq_any  = nmi_i | ext_req | per_hit[`NUM_PER];
	wire [11:0] irq_code = nmi_i ? `C_NMI :
		(ext_req ? ext_code : per_code[`NUM_PER]);

	// ****************************************************************
	// Acceptance policy and status word
	// ****************************************************************
	wire blk = status_word_o[`SW_BLK];
	// Exceptions outrank interrupts; interrupts wait while the block flag is set, exceptions restart
	wire exc_take  = !in_reset && exc_req_i && exc_kind_ok && !blk;
	wire exc_fatal = !in_reset && exc_req_i && blk;
	wire irq_take  = !in_reset && irq_any && !blk && !exc_req_i;
	assign irq_pending_o = irq_any & blk;
	// Entry raises privilege, bank and block together; the mask is kept
	wire [31:0] sw_enter = status_word_o | (32'h1 << `SW_PRIV) |
		(32'h1 << `SW_BANK) | (32'h1 << `SW_BLK);
	wire swcall = exc_take && exc_kind_i == `K_SWCALL;

	always @(posedge mclk_i)
	begin
		// A blocked exception restarts at the vector, causes untouched
		if (rst_i || in_reset || exc_fatal)
		begin
			status_word_o <= `SW_RST;
			redirect_o    <= !in_reset || rst_i ? exc_fatal : 1'b0;
			redirect_pc_o <= `RST_VEC;
			irq_taken_o   <= 1'b0;
			if (rst_i)
			begin
				saved_pc_o          <= 32'h00000000;
				saved_status_word_o <= 32'h00000000;
			end
		end
		else
		begin
			redirect_o  <= 1'b0;
			irq_taken_o <= 1'b0;
			if (state_ff == S_VEC)
			begin
				redirect_o    <= 1'b1;
				redirect_pc_o <= `RST_VEC;
			end
			else if (exc_take || irq_take)
			begin
				saved_pc_o          <= (swcall || irq_take) ? next_pc_i
					: cur_pc_i;
				saved_status_word_o <= status_word_o;
				status_word_o       <= sw_enter;
				irq_taken_o         <= irq_take;
			end
			else if (rte_i)
			begin
				status_word_o <= saved_status_word_o;
				redirect_o    <= 1'b1;
				redirect_pc_o <= saved_pc_o;
			end
			else
			begin
				// Nested handling relies on software saving first
				if (sw_wr_i)
					status_word_o <= sw_wdata_i;
				if (spc_wr_i)
					saved_pc_o <= sw_wdata_i;
				if (ssr_wr_i)
					saved_status_word_o <= sw_wdata_i;
			end
		end
	end

	// ****************************************************************
	// Register decode
	// ****************************************************************
	// Only privileged accesses to the three addresses are honoured
	wire       priv   = status_word_o[`SW_PRIV];
	wire       hit_s  = (reg_addr_i == `ADDR_SCI);
	wire       hit_e  = (reg_addr_i == `ADDR_ECR);
	wire       hit_i  = (reg_addr_i == `ADDR_ICR);
	wire       acc_ok = priv & (hit_s | hit_e | hit_i);
	wire [1:0] sel    = hit_e ? 2'h1 : (hit_i ? 2'h2 : 2'h0);
	// A refused access reaches no register, so read data stay as they were

	// ****************************************************************
	// Reset effects and register access
	// ****************************************************************
	always @(posedge mclk_i)
	begin
		if (rst_i)
		begin
			cpu_reset_o <= 1'b1;
			halt_all_o  <= 1'b1;
			mem_keep_o  <= 1'b0;
			reg_err_o   <= 1'b0;
		end
		else
		begin
			cpu_reset_o <= in_reset | exc_fatal;
			halt_all_o  <= in_reset & por_ff;
			mem_keep_o  <= in_reset & ~por_ff;
			reg_err_o   <= (reg_rd_i | reg_wr_i) & ~acc_ok;
		end
	end

	// Reset cause follows the latched kind on every cycle in the reset state
	wire        ecr_ld  = in_reset | exc_take;
	wire [11:0] ecr_val = in_reset ? (por_ff ? `C_POR : `C_MRST)
		: exc_code;

	// Refused accesses are masked here; inside the store a hardware load
	// beats a software write to the same register
	cause_store u_store
	(
		.mclk_i    (mclk_i),
		.rst_i     (rst_i),
		.ecr_ld_i  (ecr_ld),
		.ecr_val_i (ecr_val),
		.icr_ld_i  (irq_take),
		.icr_val_i (irq_code),
		.sci_ld_i  (swcall),
		.sci_val_i (swcall_imm_i),
		.sel_i     (sel),
		.wr_i      (reg_wr_i & acc_ok),
		.rd_i      (reg_rd_i & acc_ok),
		.wdata_i   (reg_wdata_i),
		.ecr_o     (),
		.rdata_o   (reg_rdata_o)
	);
endmodule // exception_cause_and_reset_unit

// File: exc_unit_checker.sv
// Assertion checker for the exception cause and reset unit.
// Assumes it is bound to the unit's top module; one clock domain.
`timescale 1ns/100ps
module exc_unit_checker
(
	// Clock and reset
	input wire        mclk_i,
	input wire        rst_i,
	// Requests
	input wire        exc_req_i,
	input wire [3:0]  exc_kind_i,
	input wire [31:0] cur_pc_i,
	input wire        rte_i,
	input wire        reg_rd_i,
	input wire [27:0] reg_addr_i,
	// Responses
	input wire        reg_err_o,
	input wire        redirect_o,
	input wire [31:0] redirect_pc_o,
	input wire        cpu_reset_o,
	input wire        halt_all_o,
	input wire        mem_keep_o,
	input wire        irq_taken_o,
	input wire        irq_pending_o,
	input wire [31:0] status_word_o,
	input wire [31:0] saved_pc_o,
	input wire [31:0] saved_status_word_o
);
default clocking cb @(posedge mclk_i); endclocking
default disable iff (rst_i);
// Software call saves the next PC, so it is left out here
chk_exc_accept: assert property (
	exc_req_i && exc_kind_i < 4'ha && !status_word_o[28] && !cpu_reset_o
	|=> status_word_o[30:28] == 3'h7 && saved_pc_o == $past(cur_pc_i))
	else $error("exception not accepted");
chk_blocked_exc: assert property (
	exc_req_i && exc_kind_i <= 4'ha && status_word_o[28] && !cpu_reset_o
	|=> redirect_o && redirect_pc_o == 32'ha0000000)
	else $error("blocked exception did not restart");
chk_pend_block: assert property (
	irq_pending_o |=> !irq_taken_o)
	else $error("pending request taken while blocked");
chk_taken_open: assert property (
	irq_taken_o |-> !$past(status_word_o[28]))
	else $error("interrupt taken while blocked");
chk_rte_restore: assert property (
	rte_i && !exc_req_i && status_word_o[28] && !cpu_reset_o
	|=> redirect_o && redirect_pc_o == $past(saved_pc_o)
	&& status_word_o == $past(saved_status_word_o))
	else $error("return did not restore");
chk_user_refused: assert property (
	reg_rd_i && !status_word_o[30] |=> reg_err_o)
	else $error("user access not refused");
chk_unmapped_err: assert property (
	reg_rd_i && reg_addr_i == 28'hfffffdc |=> reg_err_o)
	else $error("unmapped access not refused");
chk_manual_keep: assert property (
	mem_keep_o |-> !halt_all_o && cpu_reset_o)
	else $error("manual reset halted everything");
chk_reset_vector: assert property (
	$fell(rst_i) |-> ##[1:4] redirect_o && redirect_pc_o == 32'ha0000000)
	else $error("no fetch from reset vector");
chk_reset_flags: assert property (
	$fell(rst_i) |-> status_word_o[30:28] == 3'h7)
	else $error("reset flags not set");
endmodule // exc_unit_checker
bind exception_cause_and_reset_unit exc_unit_checker u_chk (.mclk_i,
	.rst_i, .exc_req_i, .exc_kind_i, .cur_pc_i, .rte_i, .reg_rd_i,
	.reg_addr_i, .reg_err_o, .redirect_o, .redirect_pc_o, .cpu_reset_o,
	.halt_all_o, .mem_keep_o, .irq_taken_o, .irq_pending_o,
	.status_word_o, .saved_pc_o, .saved_status_word_o);

// File: exc_event_model.sv
// Pipeline, interrupt controller and reset pins facing the unit.
// Assumes the bench calls its tasks; all changes land on rising edges.
`timescale 1ns/100ps
module exc_event_model
(
	input  wire        mclk_i,
	output reg         exc_req_o,
	output reg  [3:0]  exc_kind_o,
	output reg  [7:0]  swcall_imm_o,
	output reg  [31:0] cur_pc_o,
	output reg  [31:0] next_pc_o,
	output reg         nmi_o,
	output reg  [3:0]  level_o,
	output reg  [13:0] periph_o,
	output reg         reset_pin_n_o,
	output reg         bus_request_pin_n_o
);
initial
begin
	{exc_req_o, exc_kind_o, swcall_imm_o, nmi_o, periph_o} = 0;
	{cur_pc_o, next_pc_o} = 0;
	level_o = 4'hf;
	reset_pin_n_o = 1'b1;
	bus_request_pin_n_o = 1'b1;
end
task exc(input [3:0] k, input [7:0] imm);
begin
	@(posedge mclk_i);
	exc_req_o <= 1'b1;
	exc_kind_o <= k;
	swcall_imm_o <= imm;
	cur_pc_o <= 32'h8c001000 | k;
	next_pc_o <= 32'h8c001002 | k;
	@(posedge mclk_i);
	exc_req_o <= 1'b0;
end
endtask
task irq(input n, input [3:0] l, input [13:0] p);
begin
	@(posedge mclk_i);
	nmi_o <= n;
	level_o <= l;
	periph_o <= p;
end
endtask
// Pin level sets the reset kind, high for power-on
task pin(input on, input manual);
begin
	@(posedge mclk_i);
	reset_pin_n_o <= !on;
	bus_request_pin_n_o <= !(on && manual);
end
endtask
endmodule // exc_event_model

// File: exception_cause_and_reset_unit_tb.sv
// Self-checking bench for the exception cause and reset unit.
// Assumes the event model drives the pipeline side and reset pins.
`timescale 1ns/100ps
module exception_cause_and_reset_unit_tb;
reg         mclk_i, rst_i, rte_i, sw_wr_i, spc_wr_i, ssr_wr_i;
reg         reg_rd_i, reg_wr_i;
reg  [31:0] sw_wdata_i;
reg  [27:0] reg_addr_i;
reg  [11:0] reg_wdata_i, rv;
wire        exc_req_i, nmi_i, rpn, bpn, reg_err_o, redirect_o, cpu_reset_o;
wire        halt_all_o, mem_keep_o, irq_taken_o, irq_pending_o;
wire [3:0]  exc_kind_i, lvl;
wire [7:0]  imm;
wire [13:0] per;
wire [11:0] reg_rdata_o;
wire [31:0] cpc, npc, redirect_pc_o, status_word_o, saved_pc_o, ssw;
reg         re, got;
integer     mismatches, n_tests, i;
reg  [11:0] codes [0:10];
exc_event_model pm (.mclk_i(mclk_i), .exc_req_o(exc_req_i),
	.exc_kind_o(exc_kind_i), .swcall_imm_o(imm), .cur_pc_o(cpc),
	.next_pc_o(npc), .nmi_o(nmi_i), .level_o(lvl), .periph_o(per),
	.reset_pin_n_o(rpn), .bus_request_pin_n_o(bpn));
exception_cause_and_reset_unit dut (.mclk_i(mclk_i), .rst_i(rst_i),
	.reset_pin_n_i(rpn), .bus_request_pin_n_i(bpn), .exc_req_i(exc_req_i),
	.exc_kind_i(exc_kind_i), .swcall_imm_i(imm), .cur_pc_i(cpc),
	.next_pc_i(npc), .nmi_i(nmi_i), .encoded_interrupt_level_i(lvl),
	.periph_irq_i(per), .rte_i(rte_i), .sw_wr_i(sw_wr_i),
	.sw_wdata_i(sw_wdata_i), .spc_wr_i(spc_wr_i), .ssr_wr_i(ssr_wr_i),
	.reg_rd_i(reg_rd_i), .reg_wr_i(reg_wr_i), .reg_addr_i(reg_addr_i),
	.reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
	.reg_err_o(reg_err_o), .redirect_o(redirect_o),
	.redirect_pc_o(redirect_pc_o), .cpu_reset_o(cpu_reset_o),
	.halt_all_o(halt_all_o), .mem_keep_o(mem_keep_o),
	.irq_taken_o(irq_taken_o), .irq_pending_o(irq_pending_o),
	.status_word_o(status_word_o), .saved_pc_o(saved_pc_o),
	.saved_status_word_o(ssw));
initial
begin
	mclk_i = 1'b0;
	forever #10 mclk_i = !mclk_i;
end
task chk(input [8*10:1] nm, input [31:0] s, input [31:0] e);
begin
	n_tests = n_tests + 1;
	if (s !== e)
	begin
		mismatches = mismatches + 1;
		$display("CHECK FAILED %0s expected %h seen %h", nm, e, s);
	end
end
endtask
task test_done;
begin
	$display("mismatches %0d, n_tests %0d", mismatches, n_tests);
	if (mismatches == 0 && n_tests > 0)
		$display("No errors found");
	else
		$display("Errors were found");
	$finish;
end
endtask
task rd(input [27:0] a);
begin
	@(posedge mclk_i);
	reg_rd_i <= 1'b1;
	reg_addr_i <= a;
	@(posedge mclk_i);
	reg_rd_i <= 1'b0;
	#1 rv = reg_rdata_o;
	re = reg_err_o;
end
endtask
task wr(input [27:0] a, input [11:0] d);
begin
	@(posedge mclk_i);
	reg_wr_i <= 1'b1;
	reg_addr_i <= a;
	reg_wdata_i <= d;
	@(posedge mclk_i);
	reg_wr_i <= 1'b0;
end
endtask
// Sel: 0 status word, 1 saved PC, 2 saved status, 3 return
task wp(input [1:0] sel, input [31:0] d);
begin
	@(posedge mclk_i);
	sw_wdata_i <= d;
	{rte_i, ssr_wr_i, spc_wr_i, sw_wr_i} <= 4'h1 << sel;
	@(posedge mclk_i);
	{rte_i, ssr_wr_i, spc_wr_i, sw_wr_i} <= 4'h0;
end
endtask
task wt;
begin
	got = 1'b0;
	repeat (10)
	begin
		@(posedge mclk_i);
		#1 if (irq_taken_o === 1'b1) got = 1'b1;
	end
end
endtask
task pinrst(input manual);
begin
	pm.pin(1'b1, manual);
	repeat (5) @(posedge mclk_i);
	#1 chk("halt", halt_all_o, !manual);
	chk("keep", mem_keep_o, manual);
	pm.pin(1'b0, 1'b0);
	repeat (8) @(posedge mclk_i);
	rd(28'hfffffd4);
	chk("pin cause", rv, manual ? 12'h020 : 12'h000);
end
endtask
initial
begin
	#200000 mismatches = mismatches + 1;
	test_done;
end
// ****************************************
// Main sequence
// ****************************************
initial
begin
	rst_i = 1'b1;
	n_tests = 0;
	{rte_i, sw_wr_i, spc_wr_i, ssr_wr_i, reg_rd_i, reg_wr_i} = 0;
	{sw_wdata_i, reg_addr_i, reg_wdata_i} = 0;
	mismatches = 0;
	{codes[0], codes[1], codes[2], codes[3]} = 48'h0400600800a0;
	{codes[4], codes[5], codes[6], codes[7]} = 48'h0c00e0100180;
	{codes[8], codes[9], codes[10]} = 36'h1a01e0160;
	repeat (10) @(posedge mclk_i);
	rst_i <= 1'b0;
	repeat (6) @(posedge mclk_i);
	#1 chk("flags", status_word_o[30:28], 3'h7);
	rd(28'hfffffd4);
	chk("por cause", rv, 12'h000);
	for (i = 0; i < 11; i = i + 1)
	begin
		wp(0, 32'h40000000);
		pm.exc(i, 8'h5a + i);
		#1 if (i < 10) chk("saved pc", saved_pc_o, 32'h8c001000 | i);
		rd(28'hfffffd4);
		chk("exc cause", rv, codes[i]);
	end
	chk("last", rv, 12'h160);
	rd(28'hfffffd0);
	chk("imm", rv, 12'h064);
	pm.exc(4'h7, 8'h00);
	#1 chk("restart", redirect_pc_o, 32'ha0000000);
	chk("redirect", redirect_o, 1'b1);
	chk("cpu reset", cpu_reset_o, 1'b1);
	repeat (6) @(posedge mclk_i);
	rd(28'hfffffd4);
	chk("kept cause", rv, 12'h160);
	pm.irq(1'b1, 4'hf, 14'h0);
	wt;
	chk("pending", {got, irq_pending_o}, 2'b01);
	wp(0, 32'h40000000);
	wt;
	chk("nmi taken", got, 1'b1);
	rd(28'hfffffd8);
	chk("nmi", rv, 12'h1c0);
	for (i = 0; i < 30; i = i + 1)
	begin
		pm.irq(1'b0, i < 16 ? i : 4'hf, i < 16 ? 14'h0 : 14'h1 << (i - 16));
		wp(0, 32'h40000000);
		wt;
		chk("taken", got, i != 15);
		rd(28'hfffffd8);
		if (i < 15) chk("ext", rv, 12'h200 + i * 12'h20);
		else if (i > 15) chk("periph", rv, 12'h200 + i * 12'h20);
	end
	// Requests must drop before the return, or one is taken at once
	pm.irq(1'b0, 4'hf, 14'h0);
	wr(28'hfffffd4, 12'h5c3);
	rd(28'hfffffd4);
	chk("sw cause", rv, 12'h5c3);
	wr(28'hfffffd8, 12'h3a5);
	rd(28'hfffffd8);
	chk("sw irq", rv, 12'h3a5);
	wr(28'hfffffd0, 12'h0e7);
	rd(28'hfffffd0);
	chk("sw imm", rv, 12'h0e7);
	rd(28'hfffffdc);
	chk("unmapped", re, 1'b1);
	wp(0, 32'h50000000);
	wp(1, 32'h8c0012a4);
	wp(2, 32'h000000f0);
	wp(3, 32'h0);
	#1 chk("ret pc", redirect_pc_o, 32'h8c0012a4);
	chk("ret sw", status_word_o, 32'h000000f0);
	chk("ret go", redirect_o, 1'b1);
	rd(28'hfffffd4);
	chk("user", re, 1'b1);
	pinrst(1'b1);
	pinrst(1'b0);
	test_done;
end
endmodule // exception_cause_and_reset_unit_tb
